// [logic/boec_classifier.sv]
// Branch outcome classifier with four event counters on an APB slave.
// Assumes outcome inputs are synchronous to mclk and pulse once per resolved branch or bundle.
`timescale 1ns/1ps
module boec_classifier
  import boec_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    reset_n,
  input  wire boec_pkg::boec_outcome_s outcome,
  input  wire boec_pkg::boec_apb_req_s apb_req,
  output logic                         pready,
  output logic [31:0]                  prdata,
  output logic                         pslverr,
  output logic [3:0]                   inc_pulse
);
  import boec_pkg::*;

  logic [31:0] cfg_q   [BOEC_NUM_CTR];
  logic [31:0] count_q [BOEC_NUM_CTR];
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic [3:0]  inc_q;

  // Code 0E uses mw_ev and mw_ok; code 0F uses br_ev, s1 and s2
  wire mw_ev  = outcome.valid && outcome.multiway;
  wire br_ev  = outcome.valid && !outcome.multiway;
  wire mw_ok  = !outcome.wrong_path && !outcome.wrong_target;
  wire s1     = outcome.stage == BOEC_STG_FIRST;
  wire s2     = outcome.stage == BOEC_STG_SECOND;

  // Hits for code 0E, indexed by unit mask
  logic [15:0] mw_hit;
  assign mw_hit[BOEC_UM_MW_ALL]        = mw_ev;
  assign mw_hit[BOEC_UM_MW_CORRECT]    = mw_ev && mw_ok;
  assign mw_hit[BOEC_UM_MW_WPATH]      = mw_ev && outcome.wrong_path;
  assign mw_hit[BOEC_UM_MW_WTARGET]    = mw_ev && outcome.any_taken && outcome.wrong_target;
  assign mw_hit[4]                     = 1'b0;
  assign mw_hit[5]                     = 1'b0;
  assign mw_hit[6]                     = 1'b0;
  assign mw_hit[7]                     = 1'b0;
  assign mw_hit[BOEC_UM_MW_NT_ALL]     = mw_ev && !outcome.any_taken;
  assign mw_hit[BOEC_UM_MW_NT_CORRECT] = mw_ev && !outcome.any_taken && mw_ok;
  assign mw_hit[BOEC_UM_MW_NT_WPATH]   = mw_ev && !outcome.any_taken && outcome.wrong_path;
  // No target exists on an all-not-taken bundle
  assign mw_hit[BOEC_UM_MW_NT_WTARGET] = 1'b0;
  assign mw_hit[BOEC_UM_MW_TK_ALL]     = mw_ev && outcome.any_taken;
  assign mw_hit[BOEC_UM_MW_TK_CORRECT] = mw_ev && outcome.any_taken && mw_ok;
  assign mw_hit[BOEC_UM_MW_TK_WPATH]   = mw_ev && outcome.any_taken && outcome.wrong_path;
  assign mw_hit[BOEC_UM_MW_TK_WTARGET] = mw_hit[BOEC_UM_MW_WTARGET];

  // Hits for code 0F; actual outcome is any_taken
  wire nt_ok    = br_ev && !outcome.any_taken && !outcome.pred_taken;
  wire tk_ok    = br_ev && outcome.any_taken && outcome.pred_taken;
  logic [15:0] pt_hit;
  assign pt_hit[BOEC_UM_ANY_NT_WRONG] = br_ev && !outcome.any_taken && outcome.pred_taken;
  assign pt_hit[BOEC_UM_ANY_TK_WRONG] = br_ev && outcome.any_taken && !outcome.pred_taken;
  assign pt_hit[BOEC_UM_ANY_NT_OK]    = nt_ok;
  assign pt_hit[BOEC_UM_ANY_TK_OK]    = tk_ok;
  assign pt_hit[BOEC_UM_S1_NT_WRONG]  = pt_hit[BOEC_UM_ANY_NT_WRONG] && s1;
  // First stage only predicts taken, so these stay silent
  assign pt_hit[BOEC_UM_S1_TK_WRONG]  = 1'b0;
  assign pt_hit[BOEC_UM_S1_NT_OK]     = 1'b0;
  assign pt_hit[BOEC_UM_S1_TK_OK]     = tk_ok && s1;
  assign pt_hit[8]                    = 1'b0;
  assign pt_hit[9]                    = 1'b0;
  assign pt_hit[BOEC_UM_S2_NT_OK]     = nt_ok && s2;
  assign pt_hit[11]                   = 1'b0;
  assign pt_hit[12]                   = 1'b0;
  assign pt_hit[13]                   = 1'b0;
  assign pt_hit[14]                   = 1'b0;
  assign pt_hit[15]                   = 1'b0;

  function automatic logic ctr_hit(input logic [31:0] cfg, input logic [15:0] mw,
                                   input logic [15:0] pt, input boec_outcome_s o);
    logic [7:0] code;
    logic [3:0] um;
    logic       qual;
    code = cfg[BOEC_CFG_CODE_LSB +: 8];
    um   = cfg[BOEC_CFG_UMASK_LSB +: 4];
    // Data-address qualification bit is ignored here
    qual = (!cfg[BOEC_CFG_IAR_BIT] || o.iar_match) && (!cfg[BOEC_CFG_OPC_BIT] || o.opc_match);
    ctr_hit = cfg[BOEC_CFG_EN_BIT] && qual &&
              (((code == BOEC_CODE_MULTIWAY) && mw[um]) ||
               ((code == BOEC_CODE_PATH) && pt[um]));
  endfunction

  logic [3:0] hit_d;
  always_comb
  begin
    for (int i = 0; i < BOEC_NUM_CTR; i++)
    begin
      hit_d[i] = ctr_hit(cfg_q[i], mw_hit, pt_hit, outcome);
    end
  end

  // APB decode: zero-wait, unmapped offsets answer with slverr
  wire        setup    = apb_req.psel && !apb_req.penable;
  wire        access   = apb_req.psel && apb_req.penable && pready_q;
  wire [31:0] rel      = apb_req.paddr - BOEC_CTR_BASE;
  wire [1:0]  sel_ctr  = rel[5:4];
  wire [3:0]  sel_off  = rel[3:0];
  wire        in_range = (apb_req.paddr >= BOEC_CTR_BASE) &&
                         (rel < (BOEC_CTR_STRIDE * BOEC_NUM_CTR));
  wire        is_cfg   = in_range && (sel_off == BOEC_OFF_CFG);
  wire        is_cnt   = in_range && (sel_off == BOEC_OFF_COUNT);
  wire        mapped   = is_cfg || is_cnt;
  wire [31:0] rd_val   = is_cfg ? cfg_q[sel_ctr] : (is_cnt ? count_q[sel_ctr] : 32'h0000_0000);
  wire        wr_cfg   = access && apb_req.pwrite && is_cfg;
  wire        wr_cnt   = access && apb_req.pwrite && is_cnt;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q  <= setup;
      pslverr_q <= setup && !mapped;
      prdata_q  <= (setup && !apb_req.pwrite) ? rd_val : 32'h0000_0000;
    end
  end

  // One increment per cycle per counter; a software write wins
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      inc_q <= 4'h0;
      for (int i = 0; i < BOEC_NUM_CTR; i++)
      begin
        cfg_q[i]   <= BOEC_CFG_RESET;
        count_q[i] <= 32'h0000_0000;
      end
    end
    else
    begin
      inc_q <= hit_d;
      for (int i = 0; i < BOEC_NUM_CTR; i++)
      begin
        if (wr_cfg && (sel_ctr == i[1:0]))
          cfg_q[i] <= apb_req.pwdata & BOEC_CFG_WMASK;
        if (wr_cnt && (sel_ctr == i[1:0]))
          count_q[i] <= apb_req.pwdata;
        else if (hit_d[i])
          count_q[i] <= count_q[i] + 32'h0000_0001;
      end
    end
  end

  assign pready    = pready_q;
  assign prdata    = prdata_q;
  assign pslverr   = pslverr_q;
  assign inc_pulse = inc_q;

  a_nt_target_zero: assert property (@(posedge mclk) disable iff (!reset_n)
    (cfg_q[0][7:0] == 8'h0E && cfg_q[0][11:8] == 4'hB) |=> !inc_pulse[0])
    else $error("not-taken wrong-target counted");
  a_s1_never_nt: assert property (@(posedge mclk) disable iff (!reset_n)
    (cfg_q[0][7:0] == 8'h0F && (cfg_q[0][11:8] == 4'h6 || cfg_q[0][11:8] == 4'h5)) |=> !inc_pulse[0])
    else $error("first-stage zero event counted");
  a_tk_target_same: assert property (@(posedge mclk) disable iff (!reset_n)
    mw_hit[BOEC_UM_MW_TK_WTARGET] == (mw_hit[BOEC_UM_MW_TK_ALL] && outcome.wrong_target))
    else $error("taken wrong-target differs");
  a_nt_all_count: assert property (@(posedge mclk) disable iff (!reset_n)
    (hit_d[0] && cfg_q[0][11:0] == 12'h80E) |-> (outcome.multiway && !outcome.any_taken))
    else $error("not-taken bundle miscounted");
  a_tk_all_count: assert property (@(posedge mclk) disable iff (!reset_n)
    (cfg_q[0][16] && cfg_q[0][19:17] == 3'b000 && cfg_q[0][11:0] == 12'hC0E
     && outcome.valid && outcome.multiway && outcome.any_taken) |=> inc_pulse[0])
    else $error("taken bundle missed");
  a_nt_ok_any: assert property (@(posedge mclk) disable iff (!reset_n)
    (cfg_q[1][16] && cfg_q[1][19:17] == 3'b000 && cfg_q[1][11:0] == 12'h20F && nt_ok) |=> inc_pulse[1])
    else $error("correct not-taken missed");
  a_tk_ok_target: assert property (@(posedge mclk) disable iff (!reset_n)
    (br_ev && outcome.any_taken && outcome.pred_taken && outcome.wrong_target) |-> pt_hit[BOEC_UM_ANY_TK_OK])
    else $error("taken correct dropped on wrong target");
  a_wrong_pred: assert property (@(posedge mclk) disable iff (!reset_n)
    pt_hit[1] |-> (outcome.any_taken && !outcome.pred_taken))
    else $error("wrong not-taken event mis-decoded");
  a_count_step: assert property (@(posedge mclk) disable iff (!reset_n)
    (hit_d[2] && !wr_cnt) |=> count_q[2] == $past(count_q[2]) + 32'h0000_0001)
    else $error("counter step wrong");
  a_mw_correct: assert property (@(posedge mclk) disable iff (!reset_n)
    mw_hit[1] |-> !outcome.wrong_path && !outcome.wrong_target)
    else $error("flushed bundle counted correct");
  a_exact_match: assert property (@(posedge mclk) disable iff (!reset_n)
    hit_d[3] |-> (cfg_q[3][7:0] == 8'h0E || cfg_q[3][7:0] == 8'h0F))
    else $error("increment without code match");

  // Multiway split: not-taken and taken bundles partition the base event
  a_mw_all_hit: assert property (@(posedge mclk) disable iff (!reset_n)
    (outcome.valid && outcome.multiway) |-> mw_hit[BOEC_UM_MW_ALL])
    else $error("multiway bundle not counted");
  a_mw_all_only: assert property (@(posedge mclk) disable iff (!reset_n)
    mw_hit[BOEC_UM_MW_ALL] |-> (outcome.valid && outcome.multiway))
    else $error("multiway event without a bundle");
  a_mw_split_sum: assert property (@(posedge mclk) disable iff (!reset_n)
    mw_hit[BOEC_UM_MW_ALL] == (mw_hit[BOEC_UM_MW_NT_ALL] || mw_hit[BOEC_UM_MW_TK_ALL]))
    else $error("bundle split lost an event");
  a_mw_split_excl: assert property (@(posedge mclk) disable iff (!reset_n)
    !(mw_hit[BOEC_UM_MW_NT_ALL] && mw_hit[BOEC_UM_MW_TK_ALL]))
    else $error("bundle both taken and not taken");
  a_nt_correct_sub: assert property (@(posedge mclk) disable iff (!reset_n)
    mw_hit[BOEC_UM_MW_NT_CORRECT] |-> (mw_hit[BOEC_UM_MW_NT_ALL] && mw_hit[BOEC_UM_MW_CORRECT]))
    else $error("not-taken correct outside its parents");
  a_nt_wpath_sub: assert property (@(posedge mclk) disable iff (!reset_n)
    mw_hit[BOEC_UM_MW_NT_WPATH] |-> (mw_hit[BOEC_UM_MW_NT_ALL] && mw_hit[BOEC_UM_MW_WPATH]))
    else $error("not-taken wrong-predicate outside its parents");
  a_tk_correct_sub: assert property (@(posedge mclk) disable iff (!reset_n)
    mw_hit[BOEC_UM_MW_TK_CORRECT] |-> (mw_hit[BOEC_UM_MW_TK_ALL] && mw_hit[BOEC_UM_MW_CORRECT]))
    else $error("taken correct outside its parents");
  a_tk_wpath_sub: assert property (@(posedge mclk) disable iff (!reset_n)
    mw_hit[BOEC_UM_MW_TK_WPATH] |-> (mw_hit[BOEC_UM_MW_TK_ALL] && mw_hit[BOEC_UM_MW_WPATH]))
    else $error("taken wrong-predicate outside its parents");
  a_mw_correct_hit: assert property (@(posedge mclk) disable iff (!reset_n)
    (outcome.valid && outcome.multiway && !outcome.wrong_path && !outcome.wrong_target)
      |-> mw_hit[BOEC_UM_MW_CORRECT])
    else $error("clean bundle not counted correct");
  a_wtarget_taken: assert property (@(posedge mclk) disable iff (!reset_n)
    mw_hit[BOEC_UM_MW_WTARGET] |-> (outcome.any_taken && outcome.wrong_target))
    else $error("wrong target without a taken branch");

  // Path decode: every plain branch lands in exactly one any-predictor class
  a_path_onehot: assert property (@(posedge mclk) disable iff (!reset_n)
    (outcome.valid && !outcome.multiway) |-> $onehot(pt_hit[3:0]))
    else $error("branch not in exactly one class");
  a_path_no_mw: assert property (@(posedge mclk) disable iff (!reset_n)
    outcome.multiway |-> (pt_hit == 16'h0000))
    else $error("path event on a multiway bundle");
  a_any_nt_wrong: assert property (@(posedge mclk) disable iff (!reset_n)
    (br_ev && !outcome.any_taken && outcome.pred_taken) |-> pt_hit[BOEC_UM_ANY_NT_WRONG])
    else $error("wrong taken prediction missed");
  a_nt_ok_only: assert property (@(posedge mclk) disable iff (!reset_n)
    pt_hit[BOEC_UM_ANY_NT_OK] |-> (!outcome.any_taken && !outcome.pred_taken))
    else $error("correct not-taken mis-decoded");
  a_s1_nt_hit: assert property (@(posedge mclk) disable iff (!reset_n)
    (br_ev && !outcome.any_taken && outcome.pred_taken && outcome.stage == BOEC_STG_FIRST)
      |-> pt_hit[BOEC_UM_S1_NT_WRONG])
    else $error("first-stage wrong taken missed");
  a_s1_nt_only: assert property (@(posedge mclk) disable iff (!reset_n)
    pt_hit[BOEC_UM_S1_NT_WRONG] |-> (!outcome.any_taken && outcome.stage == BOEC_STG_FIRST))
    else $error("first-stage wrong taken mis-decoded");
  a_s1_tk_hit: assert property (@(posedge mclk) disable iff (!reset_n)
    (br_ev && outcome.any_taken && outcome.pred_taken && outcome.stage == BOEC_STG_FIRST)
      |-> pt_hit[BOEC_UM_S1_TK_OK])
    else $error("first-stage correct taken missed");
  a_s1_tk_only: assert property (@(posedge mclk) disable iff (!reset_n)
    pt_hit[BOEC_UM_S1_TK_OK] |-> (outcome.any_taken && outcome.stage == BOEC_STG_FIRST))
    else $error("first-stage correct taken mis-decoded");
  a_s2_nt_hit: assert property (@(posedge mclk) disable iff (!reset_n)
    (br_ev && !outcome.any_taken && !outcome.pred_taken && outcome.stage == BOEC_STG_SECOND)
      |-> pt_hit[BOEC_UM_S2_NT_OK])
    else $error("second-stage correct not-taken missed");
  a_s2_nt_only: assert property (@(posedge mclk) disable iff (!reset_n)
    pt_hit[BOEC_UM_S2_NT_OK] |-> (!outcome.pred_taken && outcome.stage == BOEC_STG_SECOND))
    else $error("second-stage correct not-taken mis-decoded");
  a_s1_zero_pulse: assert property (@(posedge mclk) disable iff (!reset_n)
    (cfg_q[2][BOEC_CFG_CODE_LSB +: 8] == BOEC_CODE_PATH && cfg_q[2][BOEC_CFG_UMASK_LSB +: 4] == BOEC_UM_S1_TK_WRONG)
      |=> !inc_pulse[2])
    else $error("first-stage zero event pulsed");

  // Qualification and counter updates
  a_iar_gate: assert property (@(posedge mclk) disable iff (!reset_n)
    (cfg_q[2][BOEC_CFG_IAR_BIT] && !outcome.iar_match) |-> !hit_d[2])
    else $error("address-range qualifier ignored");
  a_opc_gate: assert property (@(posedge mclk) disable iff (!reset_n)
    (cfg_q[0][BOEC_CFG_OPC_BIT] && !outcome.opc_match) |-> !hit_d[0])
    else $error("opcode qualifier ignored");
  a_dar_ignored: assert property (@(posedge mclk) disable iff (!reset_n)
    (cfg_q[1][BOEC_CFG_EN_BIT +: 4] == 4'h9 && cfg_q[1][11:0] == {BOEC_UM_ANY_NT_OK, BOEC_CODE_PATH} && nt_ok)
      |=> inc_pulse[1])
    else $error("data-range bit blocked an event");
  a_disabled_quiet: assert property (@(posedge mclk) disable iff (!reset_n)
    !cfg_q[2][BOEC_CFG_EN_BIT] |-> !hit_d[2])
    else $error("disabled counter hit");
  a_count_hold: assert property (@(posedge mclk) disable iff (!reset_n)
    (!hit_d[1] && !wr_cnt) |=> (count_q[1] == $past(count_q[1])))
    else $error("counter moved without an event");
  a_count_write: assert property (@(posedge mclk) disable iff (!reset_n)
    (wr_cnt && sel_ctr == 2'h0) |=> (count_q[0] == $past(apb_req.pwdata)))
    else $error("count write lost");
  a_cfg_write: assert property (@(posedge mclk) disable iff (!reset_n)
    (wr_cfg && sel_ctr == 2'h3) |=> (cfg_q[3] == ($past(apb_req.pwdata) & BOEC_CFG_WMASK)))
    else $error("config write lost");
  a_pulse_count: assert property (@(posedge mclk) disable iff (!reset_n)
    (inc_pulse[3] && !($past(wr_cnt) && $past(sel_ctr) == 2'h3))
      |-> (count_q[3] == $past(count_q[3]) + 32'h0000_0001))
    else $error("pulse without count step");

  // Register bus answer timing
  a_ready_pulse: assert property (@(posedge mclk) disable iff (!reset_n)
    pready |=> !pready)
    else $error("ready held too long");
  a_ready_after_setup: assert property (@(posedge mclk) disable iff (!reset_n)
    (apb_req.psel && !apb_req.penable) |=> pready)
    else $error("ready missing after setup");
  a_err_with_ready: assert property (@(posedge mclk) disable iff (!reset_n)
    pslverr |-> pready)
    else $error("error without ready");
  a_rdata_idle: assert property (@(posedge mclk) disable iff (!reset_n)
    !pready |-> (prdata == 32'h0000_0000))
    else $error("read data outside answer");
endmodule

// [logic/boec_pkg.sv]
// Constants, carrier types and the event-code map of the branch outcome event classifier.
// Assumes one core clock, and branch outcomes that arrive on that clock from the branch pipeline.
package boec_pkg;
  localparam logic [31:0] BOEC_CTR_BASE      = 32'h0000_0000;
  localparam logic [31:0] BOEC_CTR_STRIDE    = 32'h0000_0010;
  localparam logic [3:0]  BOEC_OFF_CFG       = 4'h0;
  localparam logic [3:0]  BOEC_OFF_COUNT     = 4'h4;
  localparam int          BOEC_NUM_CTR       = 4;
  localparam int          BOEC_FIRST_CTR     = 4;
  localparam int          BOEC_CFG_CODE_LSB  = 0;
  localparam int          BOEC_CFG_UMASK_LSB = 8;
  localparam int          BOEC_CFG_EN_BIT    = 16;
  localparam int          BOEC_CFG_IAR_BIT   = 17;
  localparam int          BOEC_CFG_OPC_BIT   = 18;
  localparam int          BOEC_CFG_DAR_BIT   = 19;
  localparam logic [31:0] BOEC_CFG_RESET     = 32'h0000_0000;
  localparam logic [31:0] BOEC_CFG_WMASK     = 32'h000F_0FFF;
  localparam logic [7:0]  BOEC_CODE_MULTIWAY = 8'h0E;
  localparam logic [7:0]  BOEC_CODE_PATH     = 8'h0F;
  localparam logic [3:0]  BOEC_UM_MW_ALL        = 4'h0;
  localparam logic [3:0]  BOEC_UM_MW_CORRECT    = 4'h1;
  localparam logic [3:0]  BOEC_UM_MW_WPATH      = 4'h2;
  localparam logic [3:0]  BOEC_UM_MW_WTARGET    = 4'h3;
  localparam logic [3:0]  BOEC_UM_MW_NT_ALL     = 4'h8;
  localparam logic [3:0]  BOEC_UM_MW_NT_CORRECT = 4'h9;
  localparam logic [3:0]  BOEC_UM_MW_NT_WPATH   = 4'hA;
  localparam logic [3:0]  BOEC_UM_MW_NT_WTARGET = 4'hB;
  localparam logic [3:0]  BOEC_UM_MW_TK_ALL     = 4'hC;
  localparam logic [3:0]  BOEC_UM_MW_TK_CORRECT = 4'hD;
  localparam logic [3:0]  BOEC_UM_MW_TK_WPATH   = 4'hE;
  localparam logic [3:0]  BOEC_UM_MW_TK_WTARGET = 4'hF;
  localparam logic [3:0]  BOEC_UM_ANY_NT_WRONG  = 4'h0;
  localparam logic [3:0]  BOEC_UM_ANY_TK_WRONG  = 4'h1;
  localparam logic [3:0]  BOEC_UM_ANY_NT_OK     = 4'h2;
  localparam logic [3:0]  BOEC_UM_ANY_TK_OK     = 4'h3;
  localparam logic [3:0]  BOEC_UM_S1_NT_WRONG   = 4'h4;
  localparam logic [3:0]  BOEC_UM_S1_TK_WRONG   = 4'h5;
  localparam logic [3:0]  BOEC_UM_S1_NT_OK      = 4'h6;
  localparam logic [3:0]  BOEC_UM_S1_TK_OK      = 4'h7;
  localparam logic [3:0]  BOEC_UM_S2_NT_OK      = 4'hA;

  typedef enum logic [1:0] {BOEC_STG_FIRST, BOEC_STG_SECOND, BOEC_STG_THIRD} boec_stage_e;

  // One branch resolution from the pipeline; valid for exactly one cycle
  typedef struct packed {
    logic        valid;
    logic        multiway;
    logic        any_taken;
    logic        pred_taken;
    logic        wrong_path;
    logic        wrong_target;
    boec_stage_e stage;
    logic        iar_match;
    logic        opc_match;
  } boec_outcome_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } boec_apb_req_s;
endpackage

// [tb/boec_branch_pipe.sv]
// Stand-in for the branch pipeline: emits one resolved outcome per cycle while go is high.
// Assumes go and shape come from the bench, changed just after mclk rises.
`timescale 1ns/1ps
module boec_branch_pipe
  import boec_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    reset_n,
  input  wire logic                    go,
  input  wire boec_pkg::boec_outcome_s shape,
  output boec_pkg::boec_outcome_s      outcome
);
  // Idle fields toggle, so a stale qualifier never passes for a held value
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
      outcome <= '0;
    else if (go)
      outcome <= {1'b1, shape[8:0]};
    else
      outcome <= {1'b0, ~outcome[8:0]};
endmodule

// [tb/boec_classifier_bench.sv]
// Self-checking bench: APB register checks, then one classified event per case, three in the final case.
// Assumes the classifier top and the branch pipeline stand-in, one 40 MHz clock.
`timescale 1ns/1ps
module boec_classifier_bench;
  import boec_pkg::*;
  logic          mclk;
  logic          reset_n;
  logic          go;
  boec_outcome_s shape;
  boec_outcome_s outcome;
  boec_apb_req_s apb_req;
  logic          pready;
  logic [31:0]   prdata;
  logic          pslverr;
  logic [3:0]    inc_pulse;
  logic [31:0]   rd;
  logic          er;
  int            n_fail;
  int            comparisons;

  boec_branch_pipe u_boec_branch_pipe (.mclk(mclk), .reset_n(reset_n), .go(go), .shape(shape), .outcome(outcome));
  boec_classifier u_boec_classifier (.mclk(mclk), .reset_n(reset_n), .outcome(outcome), .apb_req(apb_req),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .inc_pulse(inc_pulse));

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] adr(input int i, input logic [3:0] off);
    return BOEC_CTR_BASE + BOEC_CTR_STRIDE * i + {28'h0, off};
  endfunction

  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
    @(posedge mclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
    @(posedge mclk);
    apb_req.penable <= 1'b1;
    @(posedge mclk);
    // Only the watchdog ends a hung wait
    while (pready !== 1'b1)
      @(posedge mclk);
    rd = prdata;
    er = pslverr;
    apb_req <= '0;
  endtask

  // Shape bits: multiway, taken, pred_taken, wrong_path, wrong_target, stage[1:0], iar, opc
  task automatic ev(input int c, input logic [11:0] sel, input logic [8:0] f, input int nv, input int exp,
                    input logic [3:0] q = 4'h1);
    apb(1'b1, adr(c, BOEC_OFF_CFG), {12'h000, q, 4'h0, sel});
    apb(1'b1, adr(c, BOEC_OFF_COUNT), 32'h0);
    @(posedge mclk);
    shape <= {1'b0, f};
    go <= 1'b1;
    repeat (nv) @(posedge mclk);
    go <= 1'b0;
    @(posedge mclk);
    #1;
    check({28'h0, inc_pulse}, (exp != 0) ? {28'h0, 4'h1 << c} : 32'h0);
    apb(1'b0, adr(c, BOEC_OFF_COUNT), 32'h0);
    check(rd, 32'(exp));
    apb(1'b1, adr(c, BOEC_OFF_CFG), 32'h0);
  endtask

  initial
  begin
    repeat (4000) @(posedge mclk);
    n_fail++;
    give_verdict;
  end

  initial
  begin
    reset_n = 1'b0;
    go = 1'b0;
    shape = '0;
    apb_req = '0;
    n_fail = 0;
    comparisons = 0;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    for (int i = 0; i < BOEC_NUM_CTR; i++)
    begin
      apb(1'b0, adr(i, BOEC_OFF_CFG), 32'h0);
      check(rd, BOEC_CFG_RESET);
      check({31'h0, er}, 32'h0);
      apb(1'b0, adr(i, BOEC_OFF_COUNT), 32'h0);
      check(rd, 32'h0);
    end
    apb(1'b0, 32'h0000_0008, 32'h0);
    check({rd[30:0], er}, 32'h1);
    apb(1'b1, adr(2, BOEC_OFF_CFG), 32'hFFFF_FFFF);
    apb(1'b0, adr(2, BOEC_OFF_CFG), 32'h0);
    check(rd, BOEC_CFG_WMASK);
    apb(1'b1, adr(2, BOEC_OFF_CFG), 32'h0);
    $display("test registers done");
    ev(0, 12'h80E, 9'h103, 1, 1);
    ev(1, 12'h80E, 9'h183, 1, 0);
    ev(2, 12'h90E, 9'h103, 1, 1);
    ev(3, 12'h90E, 9'h123, 1, 0);
    ev(0, 12'hA0E, 9'h123, 1, 1);
    ev(0, 12'hB0E, 9'h113, 1, 0);
    ev(0, 12'hC0E, 9'h183, 1, 1);
    ev(3, 12'hC0E, 9'h103, 1, 0);
    ev(0, 12'hD0E, 9'h183, 1, 1);
    ev(1, 12'hD0E, 9'h1A3, 1, 0);
    ev(2, 12'hE0E, 9'h1A3, 1, 1);
    ev(3, 12'hF0E, 9'h193, 1, 1);
    ev(0, 12'h30E, 9'h193, 1, 1);
    ev(1, 12'hF0E, 9'h113, 1, 0);
    ev(2, 12'h00E, 9'h103, 1, 1);
    ev(3, 12'h00E, 9'h003, 1, 0);
    ev(0, 12'h10E, 9'h193, 1, 0);
    ev(1, 12'h10E, 9'h183, 1, 1);
    $display("test multiway done");
    ev(1, 12'h20F, 9'h007, 1, 1);
    ev(3, 12'h20F, 9'h043, 1, 0);
    ev(0, 12'h20F, 9'h103, 1, 0);
    ev(1, 12'h30F, 9'h0D3, 1, 1);
    ev(2, 12'h00F, 9'h043, 1, 1);
    ev(3, 12'h10F, 9'h083, 1, 1);
    ev(0, 12'h10F, 9'h0C3, 1, 0);
    ev(0, 12'h60F, 9'h003, 1, 0);
    ev(2, 12'h50F, 9'h083, 1, 0);
    ev(3, 12'h70F, 9'h0D3, 1, 1);
    ev(0, 12'h70F, 9'h0D7, 1, 0);
    ev(1, 12'h40F, 9'h043, 1, 1);
    ev(2, 12'h40F, 9'h047, 1, 0);
    ev(3, 12'hA0F, 9'h007, 1, 1);
    ev(0, 12'hA0F, 9'h003, 1, 0);
    ev(1, 12'h210, 9'h003, 1, 0);
    $display("test path done");
    ev(2, 12'h20F, 9'h001, 1, 0, 4'h3);
    ev(3, 12'h20F, 9'h003, 1, 1, 4'h3);
    ev(0, 12'h20F, 9'h002, 1, 0, 4'h5);
    ev(1, 12'h20F, 9'h000, 1, 1, 4'h9);
    ev(2, 12'h20F, 9'h003, 1, 0, 4'h0);
    ev(3, 12'h20F, 9'h003, 3, 3);
    $display("test qualifiers done");
    give_verdict;
  end
endmodule
